// ===== design/sec_cfg_pkg.sv
/*
  Package for the OTP security word and boot status block: register indices,
  field positions, control bits and reset values.
  Assumes one 32-bit AHB-Lite slave port and one OTP read port.
*/
// How it works
// - security bit 0 set: refuse JTAG access to tile state and memory
// - security bit 1 set: refuse processor state access from other tiles
// - security bit 5 set: boot from OTP address 0, skip boot ROM
// - security bit 7 set: enable redundant OTP rows
// - bits 8 to 11 lock sectors 0 to 3 against programming
// - bit 12 set: block all OTP programming, security word included
// - bit 13 set: refuse JTAG reads and writes of the OTP
// - bit 14 set: ignore the global debug request pin
// - bits 15 to 21 have no function, readable as user bits
// - bits 22 to 31 extend the JTAG identification code
// - boot status bits 23:16 report the tile number on the switch
// - boot status bit 8 reads 1 when boot from OTP is enabled
// - boot status bits 7:0 return the sampled boot-mode pins
// - a read-only register holds the security word as loaded
package sec_cfg_pkg;
  // ----------------------------------------------------------------
  // register indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_BOOT_STATUS = 8'h03;
  localparam logic [7:0] IDX_SEC_WORD = 8'h05;
  localparam logic [7:0] IDX_CTRL = 8'h08;
  localparam logic [7:0] IDX_STATUS = 8'h09;
  // ----------------------------------------------------------------
  // security word fields
  // ----------------------------------------------------------------
  localparam int SEC_JTAG_OFF = 0;
  localparam int SEC_LINK_OFF = 1;
  localparam int SEC_BOOT_OTP = 5;
  localparam int SEC_REDUNDANT = 7;
  localparam int SEC_SECTOR_LOCK_LO = 8;
  localparam int SEC_MASTER_LOCK = 12;
  localparam int SEC_JTAG_OTP_OFF = 13;
  localparam int SEC_DEBUG_OFF = 14;
  localparam int SEC_IDEXT_LO = 22;
  localparam int IDEXT_W = 10;
  localparam logic [31:0] SEC_WORD_RESET = 32'h0000_0000;
  // ----------------------------------------------------------------
  // boot status fields
  // ----------------------------------------------------------------
  localparam int BS_TILE_LO = 16;
  localparam int BS_BOOT_OTP = 8;
  // ----------------------------------------------------------------
  // control and status bits
  // ----------------------------------------------------------------
  localparam int CTRL_PROG_ARM = 0;
  localparam int CTRL_RELOAD = 1;
  localparam int ST_LOADED = 0;
  localparam int ST_JTAG_DENY = 1;
  localparam int ST_LINK_DENY = 2;
  localparam int ST_JOTP_DENY = 3;
  localparam int ST_PROG_DENY = 4;
  localparam int OTP_AW = 12;
  localparam logic [OTP_AW-1:0] OTP_SEC_WORD_ADDR = 12'hFFF;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// ===== design/sec_word_if.sv
/*
  Carrier for the loaded security word between the loader and the top.
  Assumes one clock domain.
*/
`timescale 1ns/1ps
interface sec_word_if;
  logic [31:0] word;
  logic loaded;
  logic reload;
  modport loader (output word, output loaded, input reload);
  modport user (input word, input loaded, output reload);
endinterface // sec_word_if

// ===== design/access_gate.sv
/*
  One access gate: a request pulse gives a grant or a deny pulse one cycle later.
  Assumes req is a one-cycle pulse and allow is stable around it.
*/
`timescale 1ns/1ps
module access_gate (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic req,
  input wire logic allow,
  output logic grant,
  output logic deny
);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      grant <= 1'b0;
      deny <= 1'b0;
    end else begin
      grant <= req & allow;
      deny <= req & ~allow;
    end
  end
endmodule // access_gate

// ===== design/sec_word_loader.sv
/*
  Reads the security word from OTP after reset or on a reload request.
  Assumes the OTP answers a held read request with one valid pulse.
*/
`timescale 1ns/1ps
module sec_word_loader
  import sec_cfg_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  sec_word_if.loader sw,
  output logic otp_rd_req,
  output logic [OTP_AW-1:0] otp_rd_addr,
  input wire logic [31:0] otp_rd_data,
  input wire logic otp_rd_valid
);
  typedef enum logic [1:0] {LD_START, LD_WAIT, LD_DONE} ld_state_e;
  ld_state_e state_q;

  assign otp_rd_req = (state_q == LD_WAIT);
  assign otp_rd_addr = OTP_SEC_WORD_ADDR;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= LD_START;
      sw.word <= SEC_WORD_RESET;
      sw.loaded <= 1'b0;
    end else begin
      case (state_q)
        LD_START: begin
          sw.loaded <= 1'b0;
          state_q <= LD_WAIT;
        end
        LD_WAIT: begin
          if (otp_rd_valid) begin
            sw.word <= otp_rd_data;
            sw.loaded <= 1'b1;
            state_q <= LD_DONE;
          end
        end
        LD_DONE: begin
          if (sw.reload) begin
            state_q <= LD_START;
          end
        end
        default: state_q <= LD_START;
      endcase
    end
  end
endmodule // sec_word_loader

// ===== design/otp_security_ctrl.sv
/*
  Security word gating and boot status for one processor tile, with an
  AHB-Lite register slave. Assumes synchronous pins and an OTP read port.
*/
`timescale 1ns/1ps
module otp_security_ctrl
  import sec_cfg_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic otp_rd_req,
  output logic [OTP_AW-1:0] otp_rd_addr,
  input wire logic [31:0] otp_rd_data,
  input wire logic otp_rd_valid,
  input wire logic boot_select_pin_0,
  input wire logic boot_select_pin_1,
  input wire logic [5:0] boot_select_pin_hi,
  input wire logic [7:0] tile_number,
  input wire logic jtag_state_req,
  output logic jtag_state_grant,
  output logic jtag_state_deny,
  input wire logic link_state_req,
  output logic link_state_grant,
  output logic link_state_deny,
  input wire logic jtag_otp_req,
  output logic jtag_otp_grant,
  output logic jtag_otp_deny,
  input wire logic otp_prog_req,
  input wire logic [1:0] otp_prog_sector,
  input wire logic otp_prog_sec_word,
  output logic otp_prog_grant,
  output logic otp_prog_deny,
  input wire logic debug_req_n,
  output logic debug_halt,
  output logic boot_release,
  output logic boot_from_otp,
  output logic redundant_rows_en,
  output logic [IDEXT_W-1:0] user_id_code_extension
);
  // ----------------------------------------------------------------
  // security word loader
  // ----------------------------------------------------------------
  sec_word_if sw ();
  logic reload_q;
  assign sw.reload = reload_q;

  sec_word_loader u_loader (
    .hclk(hclk),
    .hresetn(hresetn),
    .sw(sw),
    .otp_rd_req(otp_rd_req),
    .otp_rd_addr(otp_rd_addr),
    .otp_rd_data(otp_rd_data),
    .otp_rd_valid(otp_rd_valid)
  );

  // ----------------------------------------------------------------
  // strap capture after reset release
  // ----------------------------------------------------------------
  logic cap_done_q;
  logic [7:0] boot_pins_q;
  logic [7:0] tile_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cap_done_q <= 1'b0;
      boot_pins_q <= 8'h00;
      tile_q <= 8'h00;
    end else if (!cap_done_q) begin
      cap_done_q <= 1'b1;
      boot_pins_q <= {boot_select_pin_hi, boot_select_pin_1, boot_select_pin_0};
      tile_q <= tile_number;
    end
  end

  // ----------------------------------------------------------------
  // gate conditions
  // ----------------------------------------------------------------
  logic prog_arm_q;
  logic allow_jtag;
  logic allow_link;
  logic allow_jotp;
  logic allow_prog;
  logic sector_locked;

  assign allow_jtag = sw.loaded & ~sw.word[SEC_JTAG_OFF];
  assign allow_link = sw.loaded & ~sw.word[SEC_LINK_OFF];
  assign allow_jotp = sw.loaded & ~sw.word[SEC_JTAG_OTP_OFF];
  assign sector_locked = ~otp_prog_sec_word &
    sw.word[SEC_SECTOR_LOCK_LO + int'(otp_prog_sector)];
  assign allow_prog = sw.loaded & prog_arm_q & ~sw.word[SEC_MASTER_LOCK] & ~sector_locked;

  access_gate u_gate_jtag (
    .hclk(hclk),
    .hresetn(hresetn),
    .req(jtag_state_req),
    .allow(allow_jtag),
    .grant(jtag_state_grant),
    .deny(jtag_state_deny)
  );

  access_gate u_gate_link (
    .hclk(hclk),
    .hresetn(hresetn),
    .req(link_state_req),
    .allow(allow_link),
    .grant(link_state_grant),
    .deny(link_state_deny)
  );

  access_gate u_gate_jotp (
    .hclk(hclk),
    .hresetn(hresetn),
    .req(jtag_otp_req),
    .allow(allow_jotp),
    .grant(jtag_otp_grant),
    .deny(jtag_otp_deny)
  );

  access_gate u_gate_prog (
    .hclk(hclk),
    .hresetn(hresetn),
    .req(otp_prog_req),
    .allow(allow_prog),
    .grant(otp_prog_grant),
    .deny(otp_prog_deny)
  );

  // ----------------------------------------------------------------
  // boot, debug and word-driven outputs
  // ----------------------------------------------------------------
  // hold boot until loaded
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      boot_release <= 1'b0;
      boot_from_otp <= 1'b0;
      redundant_rows_en <= 1'b0;
      user_id_code_extension <= '0;
    end else begin
      boot_release <= boot_release | sw.loaded;
      boot_from_otp <= sw.loaded & sw.word[SEC_BOOT_OTP];
      redundant_rows_en <= sw.loaded & sw.word[SEC_REDUNDANT];
      user_id_code_extension <= sw.word[SEC_IDEXT_LO +: IDEXT_W];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      debug_halt <= 1'b0;
    end else begin
      debug_halt <= ~debug_req_n & sw.loaded & ~sw.word[SEC_DEBUG_OFF];
    end
  end

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  logic addr_ok;
  logic wr_pend_q;
  logic [7:0] wr_idx_q;
  logic [7:0] idx;
  logic [4:0] status_q;
  logic [31:0] rd_mux;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addr_ok = hsel & hready & (htrans == HTRANS_NONSEQ);
  assign idx = haddr[9:2];

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (idx)
      IDX_BOOT_STATUS: begin
        rd_mux[BS_TILE_LO +: 8] = tile_q;
        rd_mux[BS_BOOT_OTP] = boot_from_otp;
        rd_mux[7:0] = boot_pins_q;
      end
      IDX_SEC_WORD: rd_mux = sw.word;
      IDX_CTRL: rd_mux[CTRL_PROG_ARM] = prog_arm_q;
      IDX_STATUS: rd_mux[4:0] = status_q;
      default: rd_mux = 32'h0000_0000;
    endcase
    if (haddr[31:10] != 22'h00_0000) begin
      rd_mux = 32'h0000_0000;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      wr_pend_q <= 1'b0;
      wr_idx_q <= 8'h00;
    end else begin
      wr_pend_q <= addr_ok & hwrite & (hsize == 3'h2) & (haddr[31:10] == 22'h00_0000);
      if (addr_ok) begin
        wr_idx_q <= idx;
        hrdata <= hwrite ? 32'h0000_0000 : rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // control and sticky status registers
  // ----------------------------------------------------------------
  logic [4:0] status_set;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prog_arm_q <= 1'b0;
      reload_q <= 1'b0;
    end else begin
      reload_q <= wr_pend_q & (wr_idx_q == IDX_CTRL) & hwdata[CTRL_RELOAD];
      if (wr_pend_q && wr_idx_q == IDX_CTRL) begin
        prog_arm_q <= hwdata[CTRL_PROG_ARM];
      end
    end
  end

  always_comb begin
    status_set = 5'h00;
    status_set[ST_JTAG_DENY] = jtag_state_deny;
    status_set[ST_LINK_DENY] = link_state_deny;
    status_set[ST_JOTP_DENY] = jtag_otp_deny;
    status_set[ST_PROG_DENY] = otp_prog_deny;
  end

  // write one to clear, a new event wins over the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q <= 5'h00;
    end else begin
      if (wr_pend_q && wr_idx_q == IDX_STATUS) begin
        status_q <= (status_q & ~hwdata[4:0]) | status_set;
      end else begin
        status_q <= status_q | status_set;
      end
      status_q[ST_LOADED] <= sw.loaded;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_jtag_lock;
    jtag_state_req && sw.word[SEC_JTAG_OFF] |=> jtag_state_deny && !jtag_state_grant;
  endproperty
  a_jtag_lock: assert property (p_jtag_lock) else $error("jtag state access not refused");

  property p_link_lock;
    link_state_req && sw.word[SEC_LINK_OFF] |=> link_state_deny && !link_state_grant;
  endproperty
  a_link_lock: assert property (p_link_lock) else $error("link access not refused");

  property p_secure_boot;
    sw.loaded && sw.word[SEC_BOOT_OTP] |=> boot_from_otp;
  endproperty
  a_secure_boot: assert property (p_secure_boot) else $error("secure boot not taken");

  property p_redundant;
    ##1 redundant_rows_en == $past(sw.loaded & sw.word[SEC_REDUNDANT]);
  endproperty
  a_redundant: assert property (p_redundant) else $error("redundant rows mismatch");

  property p_sector_lock;
    otp_prog_req && !otp_prog_sec_word && sw.word[SEC_SECTOR_LOCK_LO + int'(otp_prog_sector)]
      |=> otp_prog_deny && !otp_prog_grant;
  endproperty
  a_sector_lock: assert property (p_sector_lock) else $error("locked sector programmed");

  property p_master_lock;
    otp_prog_req && sw.word[SEC_MASTER_LOCK] |=> otp_prog_deny && !otp_prog_grant;
  endproperty
  a_master_lock: assert property (p_master_lock) else $error("master lock bypassed");

  property p_jtag_otp;
    jtag_otp_req && sw.word[SEC_JTAG_OTP_OFF] |=> jtag_otp_deny && !jtag_otp_grant;
  endproperty
  a_jtag_otp: assert property (p_jtag_otp) else $error("jtag otp access not refused");

  property p_debug_off;
    sw.word[SEC_DEBUG_OFF] |=> !debug_halt;
  endproperty
  a_debug_off: assert property (p_debug_off) else $error("debug pin not ignored");

  property p_idext;
    ##1 user_id_code_extension == $past(sw.word[SEC_IDEXT_LO +: IDEXT_W]);
  endproperty
  a_idext: assert property (p_idext) else $error("id extension mismatch");

  property p_boot_tile;
    addr_ok && !hwrite && haddr == {22'h0, IDX_BOOT_STATUS, 2'b00}
      |=> hrdata[BS_TILE_LO +: 8] == $past(tile_q) && hrdata[BS_BOOT_OTP] == $past(boot_from_otp)
        && hrdata[7:0] == $past(boot_pins_q);
  endproperty
  a_boot_tile: assert property (p_boot_tile) else $error("boot status read wrong");

  property p_sec_read;
    addr_ok && !hwrite && haddr == {22'h0, IDX_SEC_WORD, 2'b00} |=> hrdata == $past(sw.word);
  endproperty
  a_sec_read: assert property (p_sec_read) else $error("security word read wrong");

  property p_no_early;
    !sw.loaded && !boot_release |=> !boot_release && !jtag_state_grant && !debug_halt;
  endproperty
  a_no_early: assert property (p_no_early) else $error("access before word loaded");

  property p_release;
    sw.loaded |=> boot_release;
  endproperty
  a_release: assert property (p_release) else $error("boot not released");

  property p_unloaded_shut;
    !sw.loaded |=> !jtag_state_grant && !link_state_grant
      && !jtag_otp_grant && !otp_prog_grant;
  endproperty
  a_unloaded_shut: assert property (p_unloaded_shut) else $error("grant while unloaded");

  property p_debug_on;
    !debug_req_n && sw.loaded && !sw.word[SEC_DEBUG_OFF] |=> debug_halt;
  endproperty
  a_debug_on: assert property (p_debug_on) else $error("debug request lost");
endmodule // otp_security_ctrl

// ===== verif/otp_model.sv
/*
  Behavioural OTP array answering the security word read port.
  Assumes the loader holds otp_rd_req until it has taken one valid pulse.
*/
`timescale 1ns/1ps
module otp_model
  import sec_cfg_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic otp_rd_req,
  input wire logic [OTP_AW-1:0] otp_rd_addr,
  input wire logic [31:0] stored_word,
  input wire logic [7:0] delay,
  output logic [31:0] otp_rd_data,
  output logic otp_rd_valid
);
  logic [7:0] wait_q;
  // ----------------------------------------------------------------
  // read answer after a programmable wait
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wait_q <= 8'h00;
      otp_rd_valid <= 1'b0;
      otp_rd_data <= 32'h0000_0000;
    end else if (otp_rd_req && !otp_rd_valid && wait_q == delay) begin
      wait_q <= 8'h00;
      otp_rd_valid <= 1'b1;
      otp_rd_data <= (otp_rd_addr == OTP_SEC_WORD_ADDR) ? stored_word : ~stored_word;
    end else begin
      // data is only meaningful in the valid cycle
      wait_q <= (otp_rd_req && !otp_rd_valid) ? wait_q + 8'h01 : 8'h00;
      otp_rd_valid <= 1'b0;
      otp_rd_data <= ~otp_rd_data;
    end
  end
endmodule // otp_model

// ===== verif/tb_top.sv
/*
  Self-checking bench for the security word block: AHB-Lite master tasks,
  access gate requests and an OTP model. Assumes a single 250 MHz clock.
*/
`timescale 1ns/1ps
module tb_top;
  import sec_cfg_pkg::*;
  localparam logic [31:0] A_BOOT = {22'h0, IDX_BOOT_STATUS, 2'b00};
  localparam logic [31:0] A_SEC = {22'h0, IDX_SEC_WORD, 2'b00};
  localparam logic [31:0] A_CTRL = {22'h0, IDX_CTRL, 2'b00};
  localparam logic [31:0] A_STAT = {22'h0, IDX_STATUS, 2'b00};
  localparam logic [31:0] W_OPEN = 32'h5540_5000;
  localparam logic [31:0] W_LOCK = 32'hB162_A9A3;
  logic hclk, hresetn, hsel, hwrite, otp_rd_req, otp_rd_valid, debug_req_n;
  logic hreadyout, hresp, debug_halt, boot_release, boot_from_otp, redundant_rows_en;
  logic otp_prog_sec_word;
  logic [1:0] htrans, otp_prog_sector;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, otp_rd_data, otp_word, rd;
  logic [OTP_AW-1:0] otp_rd_addr;
  logic [7:0] otp_delay;
  logic [3:0] req_v, grant_v, deny_v;
  logic [IDEXT_W-1:0] idext;
  int errors, tests_run;

  otp_security_ctrl otp_security_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .otp_rd_req(otp_rd_req), .otp_rd_addr(otp_rd_addr), .otp_rd_data(otp_rd_data),
    .otp_rd_valid(otp_rd_valid), .boot_select_pin_0(1'b1), .boot_select_pin_1(1'b0),
    .boot_select_pin_hi(6'h2D), .tile_number(8'h5A), .jtag_state_req(req_v[0]),
    .jtag_state_grant(grant_v[0]), .jtag_state_deny(deny_v[0]), .link_state_req(req_v[1]),
    .link_state_grant(grant_v[1]), .link_state_deny(deny_v[1]), .jtag_otp_req(req_v[2]),
    .jtag_otp_grant(grant_v[2]), .jtag_otp_deny(deny_v[2]), .otp_prog_req(req_v[3]),
    .otp_prog_sector(otp_prog_sector), .otp_prog_sec_word(otp_prog_sec_word),
    .otp_prog_grant(grant_v[3]), .otp_prog_deny(deny_v[3]), .debug_req_n(debug_req_n),
    .debug_halt(debug_halt), .boot_release(boot_release), .boot_from_otp(boot_from_otp),
    .redundant_rows_en(redundant_rows_en), .user_id_code_extension(idext));

  otp_model otp_model_i (.hclk(hclk), .hresetn(hresetn), .otp_rd_req(otp_rd_req),
    .otp_rd_addr(otp_rd_addr), .stored_word(otp_word), .delay(otp_delay),
    .otp_rd_data(otp_rd_data), .otp_rd_valid(otp_rd_valid));

  // ----------------------------------------------------------------
  // clock, checks and bus tasks
  // ----------------------------------------------------------------
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  task automatic cmp(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask

  task automatic rd_cmp(input string nm, input logic [31:0] a, input logic [31:0] exp);
    logic [31:0] d;
    ahb(1'b0, a, 32'h0, d);
    cmp(nm, exp, d);
  endtask

  // one request pulse, grant or deny checked in the following cycle
  task automatic gate(input int i, input logic g, input string nm);
    @(posedge hclk);
    req_v[i] <= 1'b1;
    @(posedge hclk);
    req_v[i] <= 1'b0;
    #1;
    cmp(nm, {30'h0, g, ~g}, {30'h0, grant_v[i], deny_v[i]});
  endtask

  task automatic wait_loaded();
    logic [31:0] st;
    int n;
    st = 32'h0;
    n = 0;
    while (st[ST_LOADED] !== 1'b1 && n < 100) begin
      ahb(1'b0, A_STAT, 32'h0, st);
      n++;
    end
    cmp("loaded", 32'h1, {31'h0, st[ST_LOADED]});
  endtask

  task automatic dbg(input logic exp);
    @(posedge hclk);
    debug_req_n <= 1'b0;
    repeat (3) @(posedge hclk);
    cmp("debug_halt", {31'h0, exp}, {31'h0, debug_halt});
    debug_req_n <= 1'b1;
  endtask

  // ----------------------------------------------------------------
  // watchdog and main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge hclk);
    errors++;
    end_sim();
  end

  initial begin
    errors = 0;
    tests_run = 0;
    hresetn = 1'b0;
    {hsel, hwrite, otp_prog_sec_word} = 3'b000;
    {htrans, otp_prog_sector, hsize} = 7'h00;
    {haddr, hwdata} = 64'h0;
    req_v = 4'h0;
    debug_req_n = 1'b1;
    otp_word = W_OPEN;
    otp_delay = 8'd12;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    rd_cmp("sec_word_reset", A_SEC, SEC_WORD_RESET);
    cmp("hresp", 32'h0, {31'h0, hresp});
    cmp("boot_release_early", 32'h0, {31'h0, boot_release});
    gate(0, 1'b0, "jtag_before_load");
    wait_loaded();
    cmp("boot_release", 32'h1, {31'h0, boot_release});
    rd_cmp("sec_word", A_SEC, W_OPEN);
    rd_cmp("boot_status", A_BOOT, 32'h005A_00B5);
    cmp("boot_from_otp", 32'h0, {31'h0, boot_from_otp});
    cmp("id_ext", 32'h155, {22'h0, idext});
    gate(0, 1'b1, "jtag_open");
    gate(1, 1'b1, "link_open");
    gate(2, 1'b1, "jtag_otp_open");
    ahb(1'b1, A_CTRL, 32'h1, rd);
    otp_prog_sector <= 2'h1;
    gate(3, 1'b0, "prog_master_lock");
    otp_prog_sec_word <= 1'b1;
    gate(3, 1'b0, "prog_word_master_lock");
    otp_prog_sec_word <= 1'b0;
    dbg(1'b0);
    // loaded plus sticky jtag and prog denies
    rd_cmp("status", A_STAT, 32'h0000_0013);
    ahb(1'b1, A_STAT, 32'h0000_001E, rd);
    rd_cmp("status_clr", A_STAT, 32'h0000_0001);
    rd_cmp("unmapped", 32'h0000_0040, 32'h0);
    ahb(1'b1, A_SEC, 32'hFFFF_FFFF, rd);
    rd_cmp("sec_word_ro", A_SEC, W_OPEN);
    // reload with the locking word and a slow answer
    otp_word <= W_LOCK;
    otp_delay <= 8'd20;
    ahb(1'b1, A_CTRL, 32'h3, rd);
    // loaded drops two edges after the reload write lands
    @(posedge hclk);
    gate(1, 1'b0, "link_during_reload");
    wait_loaded();
    cmp("boot_release_kept", 32'h1, {31'h0, boot_release});
    rd_cmp("sec_word_lock", A_SEC, W_LOCK);
    rd_cmp("boot_status_otp", A_BOOT, 32'h005A_01B5);
    cmp("boot_from_otp", 32'h1, {31'h0, boot_from_otp});
    cmp("redundant", 32'h1, {31'h0, redundant_rows_en});
    cmp("id_ext", 32'h2C5, {22'h0, idext});
    gate(0, 1'b0, "jtag_locked");
    gate(1, 1'b0, "link_locked");
    gate(2, 1'b0, "jtag_otp_locked");
    for (int s = 0; s < 4; s++) begin
      otp_prog_sector <= 2'(s);
      gate(3, (s == 1 || s == 2), "prog_sector");
    end
    otp_prog_sec_word <= 1'b1;
    gate(3, 1'b1, "prog_word_open");
    dbg(1'b1);
    end_sim();
  end
endmodule // tb_top
